// File: rtl/trace_ctl_regs.svh
// Register offsets, field positions, address width and fixed values.
`ifndef TRACE_CTL_REGS_SVH
`define TRACE_CTL_REGS_SVH
`define ADDR_W 4
`define OFF_CONTROL 4'h0
`define OFF_STATUS 4'h1
`define OFF_MODE 4'h2
`define OFF_FORMATTER_FLUSH_CONTROL_REGISTER 4'h3
`define OFF_TRIGCNT 4'h4
`define OFF_READDATA 4'h5
`define OFF_LEVEL 4'h6
`define OFF_WATERMARK 4'h7
`define OFF_EVENT 4'h8
`define CTL_CAPTURE_BIT 0
`define STS_EMPTY_BIT 0
`define STS_FULL_BIT 1
`define STS_READY_BIT 2
`define STS_FTEMPTY_BIT 3
`define FF_FORMAT_BIT 0
`define FF_TRIG_INSERT_BIT 1
`define FF_TRIG_ON_INPUT_BIT 8
`define FF_STOP_ON_FLUSH_BIT 12
`define FF_STOP_ON_TRIG_BIT 13
`define FF_DRAIN_BIT 14
`define FF_MANUAL_FLUSH_BIT 6
`define FF_FLUSH_ON_TRIG_BIT 5
`define EVT_TRIGGER_BIT 0
`define NO_DATA_WORD 32'hffffffff
`define FORMAT_PAD_BYTE 8'h00
`define RAW_END_BYTE 8'h01
`define FRAME_BYTES 16
`endif

// File: rtl/trace_ctl_pkg.sv
// Types shared by the trace capture controller.
package trace_ctl_pkg;
  typedef enum logic [2:0] {
    ST_DISABLED = 3'b000,
    ST_RUNNING = 3'b001,
    ST_STOPPING = 3'b010,
    ST_STOPPED = 3'b011,
    ST_DRAINING = 3'b100,
    ST_DISABLING = 3'b101
  } ctl_state_type;
  typedef enum logic [1:0] {
    MODE_CB = 2'b00,
    MODE_SWF = 2'b01,
    MODE_HWF = 2'b10
  } op_mode_type;
endpackage

// File: rtl/trace_capture_state_machine.sv
// Architectural state machine of a trace buffer controller.
`timescale 1ns/1ps
`include "trace_ctl_regs.svh"
module trace_capture_state_machine
  import trace_ctl_pkg::*;
#(
  parameter int LEVEL_W = 16
) (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic clk_en_in,
  input wire logic [`ADDR_W-1:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic trigger_input_in,
  input wire logic flush_done_in,
  input wire logic flush_from_sink_in,
  input wire logic stop_seq_written_in,
  input wire logic formatter_empty_in,
  input wire logic fifo_empty_in,
  input wire logic fifo_full_in,
  input wire logic buffer_empty_in,
  input wire logic scatter_gather_in,
  input wire logic bus_idle_in,
  input wire logic [LEVEL_W-1:0] fill_level_in,
  input wire logic [31:0] mem_data_in,
  output logic [31:0] reg_rdata_out,
  output logic capture_out,
  output logic drain_out,
  output logic stop_seq_out,
  output logic [7:0] pad_byte_out,
  output logic discard_out,
  output logic overwrite_out,
  output logic flush_req_out,
  output logic mem_pop_out,
  output logic [31:0] trig_count_out,
  output logic [31:0] watermark_out,
  output logic ready_out
);

  // Refuses level widths that the read path cannot carry.
  if (LEVEL_W < 1 || LEVEL_W > 32) begin : g_bad_level_width
    $error("LEVEL_W must be 1 to 32.");
  end

  // ****************************************************
  // State
  // ****************************************************
  typedef struct packed {
    ctl_state_type st;
    logic cap_en;
    op_mode_type mode;
    logic [15:0] formatter_flush_control_register;
    logic [31:0] trig;
    logic [31:0] wm;
    logic [31:0] rdata;
    logic capture;
    logic drain;
    logic stop_seq;
    logic [7:0] pad;
    logic discard;
    logic overwrite;
    logic flush_req;
    logic pop;
    logic ready;
    logic trig_seen;
    logic [2:0] t_sync;
  } state_type;

  state_type s_q;
  state_type s_d;
  logic trig_rise;
  logic stop_event;
  logic stores_empty;
  logic [31:0] status_word;

  always_comb begin
    trig_rise = s_q.t_sync[1] & ~s_q.t_sync[2];
    stop_event = (flush_done_in & ~flush_from_sink_in
                  & s_q.formatter_flush_control_register[`FF_STOP_ON_FLUSH_BIT])
               | (trig_rise & s_q.mode == MODE_CB
                  & s_q.formatter_flush_control_register[`FF_STOP_ON_TRIG_BIT]);
    stores_empty = stop_seq_written_in & formatter_empty_in
                 & (s_q.mode != MODE_HWF | fifo_empty_in);
    status_word = 32'h0;
    status_word[`STS_EMPTY_BIT] = buffer_empty_in;
    status_word[`STS_FULL_BIT] = fifo_full_in;
    // Ready flag marks the end of a session.
    status_word[`STS_READY_BIT] = s_q.ready;
    status_word[`STS_FTEMPTY_BIT] = formatter_empty_in;
  end

  // ****************************************************
  // Next state
  // ****************************************************
  always_comb begin
    s_d = s_q;
    s_d.t_sync = {s_q.t_sync[1:0], trigger_input_in};
    s_d.pop = 1'b0;
    s_d.flush_req = 1'b0;
    if (reg_write_in) begin
      case (reg_addr_in)
        `OFF_CONTROL: begin
          s_d.cap_en = reg_wdata_in[`CTL_CAPTURE_BIT];
        end
        `OFF_MODE: begin
          s_d.mode = op_mode_type'(reg_wdata_in[1:0]);
        end
        `OFF_FORMATTER_FLUSH_CONTROL_REGISTER: begin
          s_d.formatter_flush_control_register = reg_wdata_in[15:0];
          s_d.flush_req = reg_wdata_in[`FF_MANUAL_FLUSH_BIT];
        end
        `OFF_TRIGCNT: begin
          s_d.trig = reg_wdata_in;
        end
        `OFF_WATERMARK: begin
          s_d.wm = reg_wdata_in;
        end
        default: begin
        end
      endcase
    end
    if (reg_read_in) begin
      case (reg_addr_in)
        `OFF_CONTROL: s_d.rdata = {31'h0, s_q.cap_en};
        `OFF_STATUS: s_d.rdata = status_word;
        `OFF_MODE: s_d.rdata = {30'h0, s_q.mode};
        `OFF_FORMATTER_FLUSH_CONTROL_REGISTER: s_d.rdata = {16'h0, s_q.formatter_flush_control_register};
        `OFF_TRIGCNT: s_d.rdata = s_q.trig;
        `OFF_WATERMARK: s_d.rdata = s_q.wm;
        `OFF_READDATA: begin
          // All ones when formatted memory is empty.
          if (buffer_empty_in && s_q.formatter_flush_control_register[`FF_FORMAT_BIT]) begin
            s_d.rdata = `NO_DATA_WORD;
          end else begin
            // Reads served in every state, with a pop only when memory is not empty.
            s_d.rdata = mem_data_in;
            s_d.pop = ~buffer_empty_in;
          end
        end
        `OFF_LEVEL: begin
          s_d.rdata = (s_q.cap_en && !scatter_gather_in)
                    ? 32'(fill_level_in) : 32'h0;
        end
        default: s_d.rdata = 32'h0;
      endcase
    end
    case (s_q.st)
      ST_DISABLED: begin
        if (s_d.cap_en) begin
          s_d.st = ST_RUNNING;
        end
      end
      ST_RUNNING: begin
        if (!s_d.cap_en) begin
          s_d.st = ST_DISABLING;
        end else if (stop_event) begin
          s_d.st = ST_STOPPING;
        end
      end
      ST_STOPPING: begin
        // Waits here until the stop sequence is written and the stores are empty.
        if (!s_d.cap_en) begin
          s_d.st = ST_DISABLING;
        end else if (stores_empty) begin
          s_d.st = ST_STOPPED;
        end
      end
      ST_STOPPED: begin
        if (!s_d.cap_en) begin
          s_d.st = ST_DISABLED;
        end else if (s_q.mode == MODE_CB
                     && s_d.formatter_flush_control_register[`FF_DRAIN_BIT]) begin
          s_d.st = ST_DRAINING;
          s_d.formatter_flush_control_register[`FF_DRAIN_BIT] = 1'b0;
        end
      end
      ST_DRAINING: begin
        if (!s_d.cap_en) begin
          s_d.st = ST_DISABLING;
        end else if (buffer_empty_in) begin
          s_d.st = ST_STOPPED;
        end
      end
      ST_DISABLING: begin
        // Only to Disabled, after bus settles and formatter is empty.
        if (bus_idle_in && formatter_empty_in) begin
          s_d.st = ST_DISABLED;
        end
      end
      default: s_d.st = ST_DISABLED;
    endcase
    // Manual flush requests only act outside Disabled.
    s_d.flush_req = s_d.flush_req && s_d.st != ST_DISABLED;
    s_d.capture = s_d.st == ST_RUNNING;
    // Drain contents in Stopping and Draining only.
    s_d.drain = s_d.st == ST_STOPPING || s_d.st == ST_DRAINING;
    s_d.stop_seq = s_d.st == ST_STOPPING || s_d.st == ST_DISABLING;
    s_d.pad = s_q.formatter_flush_control_register[`FF_FORMAT_BIT] ? `FORMAT_PAD_BYTE
                                       : `RAW_END_BYTE;
    s_d.discard = s_d.st == ST_DISABLING;
    // Overwrite when full in Disabling so the stop sequence completes.
    s_d.overwrite = s_d.st == ST_DISABLING && fifo_full_in;
    s_d.ready = s_d.st == ST_DISABLED || s_d.st == ST_STOPPED;
    if (!s_d.cap_en && s_q.st == ST_DISABLED) begin
      s_d.ready = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_q <= '{st: ST_DISABLED, mode: MODE_CB, pad: `FORMAT_PAD_BYTE,
               ready: 1'b1, default: '0};
    end else if (clk_en_in) begin
      s_q <= s_d;
    end
  end

  assign reg_rdata_out = s_q.rdata;
  assign capture_out = s_q.capture;
  assign drain_out = s_q.drain;
  assign stop_seq_out = s_q.stop_seq;
  assign pad_byte_out = s_q.pad;
  assign discard_out = s_q.discard;
  assign overwrite_out = s_q.overwrite;
  assign flush_req_out = s_q.flush_req;
  assign mem_pop_out = s_q.pop;
  assign trig_count_out = s_q.trig;
  assign watermark_out = s_q.wm;
  assign ready_out = s_q.ready;

  // ****************************************************
  // Checks
  // ****************************************************
  sequence seq_stopped_drain;
    s_q.st == ST_STOPPED && s_q.mode == MODE_CB && s_q.cap_en
      && s_d.formatter_flush_control_register[`FF_DRAIN_BIT] && clk_en_in;
  endsequence

  a_ready_flag_states: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    s_q.ready == (s_q.st == ST_DISABLED || s_q.st == ST_STOPPED))
    else $error("Ready flag disagrees with state.");
  a_disabled_to_running: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    s_q.st == ST_DISABLED && s_d.cap_en && clk_en_in
      |=> s_q.st == ST_RUNNING)
    else $error("Enable did not start capture.");
  a_running_stop: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    s_q.st == ST_RUNNING && s_d.cap_en && stop_event && clk_en_in
      |=> s_q.st == ST_STOPPING)
    else $error("Stop event ignored.");
  a_stopping_exit: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    $past(s_q.st) == ST_STOPPING && s_q.st == ST_STOPPED
      |-> $past(stores_empty))
    else $error("Stopped before stores emptied.");
  a_drain_enter: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    seq_stopped_drain |=> s_q.st == ST_DRAINING && s_q.drain)
    else $error("Drain request not honoured.");
  a_draining_empty: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    s_q.st == ST_DRAINING && s_d.cap_en && buffer_empty_in && clk_en_in
      |=> s_q.st == ST_STOPPED)
    else $error("Draining missed empty buffer.");
  a_stopped_disable: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    s_q.st == ST_STOPPED && !s_d.cap_en && clk_en_in
      |=> s_q.st == ST_DISABLED)
    else $error("Stopped did not disable.");
  a_emergency_stop: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    (s_q.st == ST_RUNNING || s_q.st == ST_STOPPING
      || s_q.st == ST_DRAINING) && !s_d.cap_en && clk_en_in
      |=> s_q.st == ST_DISABLING && s_q.discard)
    else $error("Emergency stop missing.");
  a_disabling_exit: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    $past(s_q.st) == ST_DISABLING |-> s_q.st != ST_STOPPED)
    else $error("Disabling reached Stopped.");
  a_empty_all_ones: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    reg_read_in && clk_en_in && reg_addr_in == `OFF_READDATA
      && buffer_empty_in && s_q.formatter_flush_control_register[`FF_FORMAT_BIT]
      |=> reg_rdata_out == `NO_DATA_WORD)
    else $error("Empty formatted read not all ones.");
  a_disabled_idle: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    s_q.st == ST_DISABLED
      |-> !s_q.capture && !s_q.drain && !s_q.flush_req)
    else $error("Disabled state is not idle.");
  a_stopping_outputs: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    s_q.st == ST_STOPPING
      |-> s_q.drain && !s_q.ready && !s_q.capture)
    else $error("Stopping outputs are wrong.");
  a_stopped_no_capture: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    s_q.st == ST_STOPPED
      |-> !s_q.capture && !s_q.drain && s_q.ready)
    else $error("Stopped state still captures.");
  a_draining_outputs: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    s_q.st == ST_DRAINING
      |-> s_q.drain && !s_q.capture && !s_q.ready)
    else $error("Draining outputs are wrong.");
  a_disabling_discard: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    s_q.st == ST_DISABLING
      |-> s_q.discard && s_q.stop_seq && !s_q.ready)
    else $error("Disabling does not discard.");
  a_overwrite_full: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    s_q.overwrite
      |-> s_q.st == ST_DISABLING)
    else $error("Overwrite outside Disabling.");
  a_pad_value: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    s_q.stop_seq && $stable(s_q.formatter_flush_control_register[`FF_FORMAT_BIT])
      |-> s_q.pad == (s_q.formatter_flush_control_register[`FF_FORMAT_BIT] ? `FORMAT_PAD_BYTE
                                                : `RAW_END_BYTE))
    else $error("Stop sequence pad value wrong.");
  a_level_invalid: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    reg_read_in && clk_en_in && reg_addr_in == `OFF_LEVEL
      && !s_q.cap_en
      |=> reg_rdata_out == 32'h0)
    else $error("Fill level shown while disabled.");
  a_ready_status: assert property (
    @(posedge clk_sys_in) disable iff (!nrst_in)
    reg_read_in && clk_en_in && reg_addr_in == `OFF_STATUS
      |=> reg_rdata_out[`STS_READY_BIT] == $past(s_q.ready))
    else $error("Status ready bit disagrees.");
endmodule

// File: tb/trace_datapath_model.sv
// Behavioural datapath and trace bus partner of the capture controller.
`timescale 1ns/1ps
module trace_datapath_model (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic capture_in,
  input wire logic drain_in,
  input wire logic stop_seq_in,
  input wire logic flush_req_in,
  input wire logic hold_in,
  output logic flush_done_out,
  output logic stop_written_out,
  output logic stores_empty_out,
  output logic buffer_empty_out,
  output logic bus_idle_out
);
  logic [1:0] cnt_q;
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_q <= 2'h0;
      flush_done_out <= 1'b0;
    end else begin
      flush_done_out <= flush_req_in;
      if (!(drain_in || stop_seq_in)) begin
        cnt_q <= 2'h0;
      end else if (cnt_q != 2'h3) begin
        cnt_q <= cnt_q + 2'h1;
      end
    end
  end
  assign stop_written_out = (cnt_q == 2'h3) && stop_seq_in;
  assign stores_empty_out = !hold_in && (cnt_q == 2'h3);
  assign buffer_empty_out = !hold_in &&
    ((cnt_q == 2'h3) || !(capture_in || drain_in));
  assign bus_idle_out = !hold_in;
endmodule

// File: tb/trace_capture_state_machine_tb_top.sv
// Self-checking bench for the trace capture state machine.
`timescale 1ns/1ps
`include "trace_ctl_regs.svh"
module trace_capture_state_machine_tb_top;
  import trace_ctl_pkg::*;
  logic clk_sys_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic trig = 1'b0;
  logic sink_fl = 1'b0;
  logic hold = 1'b0;
  logic [31:0] rdata, rv;
  logic [7:0] pad;
  logic pop;
  logic [31:0] trig_cnt, wm;
  logic capture, drain, stop_seq, discard, overwrite, flush_req, ready;
  logic fl_done, stop_wr, st_empty, buf_empty, bus_idle;
  int failures = 0;
  int checked = 0;
  localparam logic [31:0] fl = 32'h1 << `FF_STOP_ON_FLUSH_BIT;
  localparam logic [31:0] mf = 32'h1 << `FF_MANUAL_FLUSH_BIT;
  localparam logic [31:0] ft = 32'h1 << `FF_FORMAT_BIT;
  localparam logic [31:0] stt = 32'h1 << `FF_STOP_ON_TRIG_BIT;
  localparam logic [31:0] dr = 32'h1 << `FF_DRAIN_BIT;
  always #2.5 clk_sys_in = ~clk_sys_in;
  trace_capture_state_machine i_trace_capture_state_machine (
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .clk_en_in(1'b1),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_write_in(wr_en),
    .reg_read_in(rd_en), .trigger_input_in(trig),
    .flush_done_in(fl_done), .flush_from_sink_in(sink_fl),
    .stop_seq_written_in(stop_wr), .formatter_empty_in(st_empty),
    .fifo_empty_in(st_empty), .fifo_full_in(hold),
    .buffer_empty_in(buf_empty), .scatter_gather_in(1'b0),
    .bus_idle_in(bus_idle), .fill_level_in(16'h0042),
    .mem_data_in(32'h1234abcd), .reg_rdata_out(rdata),
    .capture_out(capture), .drain_out(drain), .stop_seq_out(stop_seq),
    .pad_byte_out(pad), .discard_out(discard),
    .overwrite_out(overwrite), .flush_req_out(flush_req),
    .mem_pop_out(pop), .trig_count_out(trig_cnt), .watermark_out(wm),
    .ready_out(ready));
  trace_datapath_model i_trace_datapath_model (
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .capture_in(capture),
    .drain_in(drain), .stop_seq_in(stop_seq), .flush_req_in(flush_req),
    .hold_in(hold), .flush_done_out(fl_done),
    .stop_written_out(stop_wr), .stores_empty_out(st_empty),
    .buffer_empty_out(buf_empty), .bus_idle_out(bus_idle));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    if (failures == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys_in);
    wr_en <= 1'b0;
    @(posedge clk_sys_in);
    #1;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys_in);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys_in);
    rd_en <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic wait_on(input logic want_drain);
    int n;
    n = 0;
    while ((want_drain ? drain : ready) !== 1'b1 && n < 60) begin
      @(posedge clk_sys_in);
      #1;
      n++;
    end
  endtask
  task automatic t_reset();
    chk(ready, 1'b1);
    chk(capture, 1'b0);
    rd(`OFF_STATUS, rv);
    chk(rv[`STS_READY_BIT], 1'b1);
    rd(`OFF_LEVEL, rv);
    chk(rv, 32'h0);
    rd(4'hf, rv);
    chk(rv, 32'h0);
  endtask
  task automatic t_session();
    wr(`OFF_MODE, {30'h0, MODE_CB});
    wr(`OFF_FORMATTER_FLUSH_CONTROL_REGISTER, ft | fl | mf);
    repeat (4) @(posedge clk_sys_in);
    chk(ready, 1'b1);
    wr(`OFF_CONTROL, 32'h1);
    chk(capture, 1'b1);
    chk(ready, 1'b0);
    repeat (4) @(posedge clk_sys_in);
    chk(capture, 1'b1);
    rd(`OFF_LEVEL, rv);
    chk(rv, 32'h42);
    hold <= 1'b1;
    wr(`OFF_FORMATTER_FLUSH_CONTROL_REGISTER, ft | fl | mf);
    wait_on(1'b1);
    chk(drain, 1'b1);
    chk(pad, `FORMAT_PAD_BYTE);
    rd(`OFF_STATUS, rv);
    chk(rv[`STS_READY_BIT], 1'b0);
    chk(ready, 1'b0);
    rd(`OFF_READDATA, rv);
    chk(rv, 32'h1234abcd);
    chk(pop, 1'b1);
    hold <= 1'b0;
    wait_on(1'b0);
    chk({ready, capture, drain}, 3'b100);
    rd(`OFF_READDATA, rv);
    chk(rv, `NO_DATA_WORD);
    wr(`OFF_FORMATTER_FLUSH_CONTROL_REGISTER, ft | dr);
    chk({drain, ready}, 2'b10);
    wait_on(1'b0);
    chk({drain, ready}, 2'b01);
    wr(`OFF_CONTROL, 32'h0);
    chk({ready, capture, discard}, 3'b100);
  endtask
  task automatic t_emergency();
    wr(`OFF_FORMATTER_FLUSH_CONTROL_REGISTER, stt);
    wr(`OFF_CONTROL, 32'h1);
    sink_fl <= 1'b1;
    wr(`OFF_FORMATTER_FLUSH_CONTROL_REGISTER, fl | stt | mf);
    repeat (6) @(posedge clk_sys_in);
    chk(capture, 1'b1);
    sink_fl <= 1'b0;
    hold <= 1'b1;
    trig <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    trig <= 1'b0;
    wait_on(1'b1);
    chk(drain, 1'b1);
    chk(pad, `RAW_END_BYTE);
    wr(`OFF_CONTROL, 32'h0);
    chk({discard, overwrite, ready}, 3'b110);
    hold <= 1'b0;
    wait_on(1'b0);
    chk({ready, discard}, 2'b10);
    wr(`OFF_FORMATTER_FLUSH_CONTROL_REGISTER, dr);
    chk({drain, ready}, 2'b01);
    rd(`OFF_READDATA, rv);
    chk(rv, 32'h1234abcd);
  endtask
  task automatic t_hwf();
    wr(`OFF_MODE, {30'h0, MODE_HWF});
    wr(`OFF_FORMATTER_FLUSH_CONTROL_REGISTER, ft | stt);
    wr(`OFF_TRIGCNT, 32'h10);
    chk(trig_cnt, 32'h10);
    wr(`OFF_WATERMARK, 32'h3);
    chk(wm, 32'h3);
    wr(`OFF_CONTROL, 32'h1);
    trig <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    trig <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    chk(capture, 1'b1);
    wr(`OFF_FORMATTER_FLUSH_CONTROL_REGISTER, ft | fl | mf);
    wait_on(1'b0);
    chk({ready, drain}, 2'b10);
    wr(`OFF_FORMATTER_FLUSH_CONTROL_REGISTER, ft | dr);
    chk({drain, ready}, 2'b01);
    wr(`OFF_CONTROL, 32'h0);
    chk(ready, 1'b1);
    rd(`OFF_READDATA, rv);
    chk(rv, `NO_DATA_WORD);
  endtask
  initial begin
    repeat (8) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    @(posedge clk_sys_in);
    #1;
    t_reset();
    t_session();
    t_emergency();
    t_hwf();
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    failures++;
    give_verdict();
  end
endmodule
